// >>> rtl/nsb_bank.sv
// Behaviour
// - node on record end, gateway continuously
// - supply is mean of 256 at 50 kSPS
// - temperature is mean of 64 over 1.7 ms
// - streaming mode: gateway updates once at start only
// - supply is 16-bit straight binary
// - temperature is 16-bit offset binary
// - header rewritten per record and on retrieve
// - info word: rate 15:14, averages 7:0
// - info word: window in bits 13:12
// - seconds stamp split low and high words
// - command bit launches, clears when finished
// - bit 13 fetches selected record header
// - bit 14 loads selected alarm band
// - bit 12 saves alarm bands to SRAM
// - bit 10 zeroes data buffer index
// - bit 9 erases stored alarm bands
// - bit 8 clears records and buffers
// - bit 6 saves registers to flash
// - bit 5 runs flash checksum test
// - bit 3 restores factory settings, clears buffers
// - bit 2 self-test, result to diag bit 5
// - diag bit 5: one fail, zero pass
`include "nsb_defs.svh"

module nsb_bank (
	input  logic                 clk_sys,
	input  logic                 reset,
	input  logic                 sclk,
	input  logic                 cs_n,
	input  logic                 mosi,
	output logic                 miso,
	output logic                 miso_oe,
	output logic                 sup_conv,
	input  logic                 sup_vld,
	input  logic [15:0]          sup_data,
	output logic                 tmp_conv,
	input  logic                 tmp_vld,
	input  logic [15:0]          tmp_data,
	input  logic                 rt_mode,
	input  logic                 rec_done,
	input  logic                 rec_evt,
	input  logic [3:0]           rec_slot,
	input  nsb_pkg::nsb_hdr_type hdr_in,
	input  logic [15:0]          cmd_done,
	input  logic                 st_fail,
	output logic [15:0]          action_go,
	output logic [8:0]           buf_index,
	output logic [7:0]           alm_select,
	output logic [3:0]           rec_select
);

	// ============================================================
	// declarations
	nsb_pkg::nsb_state_type st_r;
	nsb_pkg::nsb_state_type st_nxt;
	logic                   frm_vld;
	logic [15:0]            frm;
	logic [6:0]             adr;
	logic [15:0]            newset;
	logic [15:0]            done;
	logic [23:0]            sup_sum;
	logic [21:0]            tmp_sum;
	logic                   rt_rise;
	logic [1:0]             sup_req;
	logic [1:0]             tmp_req;

	nsb_mem_if mif ();

	nsb_hdr_mem u_mem (
		.clk_sys (clk_sys),
		.port    (mif.mem)
	);

	// ============================================================
	// helpers
	function automatic logic [15:0] mean(
		input logic [23:0] sum,
		input logic [3:0]  sh
	);
		return 16'(sum >> sh);
	endfunction : mean

	function automatic logic [15:0] rd_word(
		input nsb_pkg::nsb_state_type s,
		input logic [6:0]             a
	);
		logic [15:0] v;
		v = 16'h0000;
		if (a == `NSB_PAGE_ADR) begin
			v = {13'h0000, s.page};
		end else if (s.page == 3'h0) begin
			if (a == `NSB_GW_TMP_ADR) v = s.gw_tmp;
			if (a == `NSB_GW_SUP_ADR) v = s.gw_sup;
		end else begin
			case (a)
			`NSB_ND_TMP_ADR: v = s.nd_tmp;
			`NSB_ND_SUP_ADR: v = s.nd_sup;
			`NSB_BUF_ADR:    v = {7'h00, s.buf_idx};
			`NSB_REC_ADR:    v = {12'h000, s.rec_ptr};
			`NSB_ALM_ADR:    v = {8'h00, s.alm_sel};
			`NSB_DIAG_ADR:   v = s.hdr.diag;
			`NSB_AXS_ADR:    v = s.hdr.ax_stat;
			`NSB_AYS_ADR:    v = s.hdr.ay_stat;
			`NSB_AXP_ADR:    v = s.hdr.ax_peak;
			`NSB_AYP_ADR:    v = s.hdr.ay_peak;
			`NSB_TSL_ADR:    v = s.hdr.ts_lo;
			`NSB_TSH_ADR:    v = s.hdr.ts_hi;
			`NSB_AXF_ADR:    v = s.hdr.ax_bin;
			`NSB_AYF_ADR:    v = s.hdr.ay_bin;
			`NSB_INF1_ADR:   v = s.hdr.info1;
			`NSB_INF2_ADR:   v = s.hdr.info2;
			default:         v = 16'h0000;
			endcase
		end
		return v;
	endfunction : rd_word

	// ============================================================
	// header store port
	assign mif.wr_en   = rec_evt;
	assign mif.wr_addr = rec_slot;
	assign mif.wr_data = hdr_in;
	assign mif.rd_en   = st_r.cmd[`NSB_CMD_RETR] && !st_r.rd_wait;
	assign mif.rd_addr = st_r.rec_ptr;

	// ============================================================
	// next state
	always_comb begin
		st_nxt  = st_r;
		frm_vld = 1'b0;
		frm     = {st_r.sh[14:0], mosi};
		adr     = frm[14:8];
		newset  = 16'h0000;
		done    = 16'h0000;
		rt_rise = rt_mode && !st_r.rt_d;
		sup_sum = st_r.sup_acc + 24'(sup_data);
		tmp_sum = st_r.tmp_acc + 22'(tmp_data);
		// record end refreshes the node, streaming start both sides
		sup_req = {rt_rise, rec_done || rt_rise};
		tmp_req = sup_req;

		st_nxt.sclk_d   = sclk;
		st_nxt.rt_d     = rt_mode;
		st_nxt.go       = 16'h0000;
		st_nxt.sup_conv = 1'b0;
		st_nxt.tmp_conv = 1'b0;

		// serial port: sampled on the rising clock edge, 16-bit frames
		st_nxt.miso_oe = !cs_n;
		st_nxt.miso    = cs_n ? 1'b0 : st_r.tx[4'hf - st_r.bits];
		if (cs_n) begin
			st_nxt.bits = 4'h0;
		end else if (sclk && !st_r.sclk_d) begin
			st_nxt.sh   = frm;
			st_nxt.bits = st_r.bits + 4'h1;
			frm_vld     = (st_r.bits == 4'hf);
		end
		// a read frame returns its word during the following frame
		if (frm_vld) begin
			st_nxt.tx = frm[15] ? 16'h0000 :
				rd_word(st_r, {adr[6:1], 1'b0});
		end

		// register writes, one byte per frame
		if (frm_vld && frm[15]) begin
			if (adr == `NSB_PAGE_ADR) begin
				st_nxt.page = frm[2:0];
			end
			if (st_r.page != 3'h0) begin
				case (adr)
				`NSB_BUF_ADR:          st_nxt.buf_idx[7:0] = frm[7:0];
				`NSB_BUF_ADR + 7'h01:  st_nxt.buf_idx[8]   = frm[0];
				`NSB_REC_ADR:          st_nxt.rec_ptr      = frm[3:0];
				`NSB_ALM_ADR:          st_nxt.alm_sel      = frm[7:0];
				`NSB_CMD_ADR:          newset[7:0]         = frm[7:0];
				`NSB_CMD_ADR + 7'h01:  newset[15:8]        = frm[7:0];
				default:               ;
				endcase
			end
		end

		// ========================================================
		// commands: outside actions finish on cmd_done
		done = cmd_done & ~`NSB_CMD_INT_MASK;
		done[`NSB_CMD_BUFZ]  = st_r.cmd[`NSB_CMD_BUFZ];
		done[`NSB_CMD_DCLR]  = st_r.cmd[`NSB_CMD_DCLR];
		done[`NSB_CMD_SWRST] = st_r.cmd[`NSB_CMD_SWRST];
		done[`NSB_CMD_RETR]  = st_r.rd_wait;
		// a new write wins over a finish in the same cycle
		st_nxt.cmd = (st_r.cmd & ~done) | newset;
		// launch pulse only for an idle bit; bits 0-3,5,6,8,9,11,12,14,15
		// are carried out by the outside engines
		st_nxt.go = newset & ~st_r.cmd;
		st_nxt.rd_wait = mif.rd_en;

		// software reset and factory restore return the settings
		if (st_r.go[`NSB_CMD_SWRST] || st_r.go[`NSB_CMD_FACT]) begin
			st_nxt.page       = 3'h0;
			st_nxt.buf_idx    = 9'h000;
			st_nxt.rec_ptr    = 4'h0;
			st_nxt.alm_sel    = 8'h00;
			st_nxt.hdr        = '0;
			st_nxt.hdr.info1  = `NSB_INFO1_RST;
		end
		if (st_r.cmd[`NSB_CMD_BUFZ]) begin
			st_nxt.buf_idx = 9'h000;
		end

		// ========================================================
		// record header: fields arrive packed as laid out in info1,
		// info2 and the stamp words
		if (rec_evt) begin
			st_nxt.hdr = hdr_in;
		end
		if (st_r.rd_wait) begin
			st_nxt.hdr = mif.rd_data;
		end
		if (cmd_done[`NSB_CMD_STEST] && st_r.cmd[`NSB_CMD_STEST]) begin
			st_nxt.hdr.diag[`NSB_DIAG_ST_BIT] = st_fail;
		end
		if (st_r.cmd[`NSB_CMD_DCLR]) begin
			st_nxt.hdr.diag = 16'h0000;
		end

		// ========================================================
		// supply: conversion start every 2500 cycles, block of 256
		if (st_r.sup_tmr == 12'h000) begin
			st_nxt.sup_tmr  = 12'(`NSB_SUP_CYC - 1);
			st_nxt.sup_conv = 1'b1;
		end else begin
			st_nxt.sup_tmr = st_r.sup_tmr - 12'h001;
		end
		st_nxt.sup_pend = st_r.sup_pend | sup_req;
		if (sup_vld) begin
			st_nxt.sup_cnt = st_r.sup_cnt + 8'h01;
			st_nxt.sup_acc = sup_sum;
			if (st_r.sup_cnt == 8'h00) begin
				// only a block begun in or after the request's cycle may satisfy it
				st_nxt.sup_acc  = 24'(sup_data);
				st_nxt.sup_arm  = st_r.sup_pend | sup_req;
				st_nxt.sup_pend = 2'b00;
			end
			if (st_r.sup_cnt == 8'(`NSB_SUP_N - 1)) begin
				if (st_r.sup_arm[1] || !rt_mode) begin
					st_nxt.gw_sup = mean(sup_sum, `NSB_SUP_SH);
				end
				if (st_r.sup_arm[0]) begin
					st_nxt.nd_sup = mean(sup_sum, `NSB_SUP_SH);
				end
				st_nxt.sup_arm = 2'b00;
			end
		end

		// ========================================================
		// temperature: 64 conversions spread over the 1.7 ms window
		if (st_r.tmp_tmr == 12'h000) begin
			st_nxt.tmp_tmr  = 12'(`NSB_TMP_CYC - 1);
			st_nxt.tmp_conv = 1'b1;
		end else begin
			st_nxt.tmp_tmr = st_r.tmp_tmr - 12'h001;
		end
		st_nxt.tmp_pend = st_r.tmp_pend | tmp_req;
		if (tmp_vld) begin
			st_nxt.tmp_cnt = st_r.tmp_cnt + 6'h01;
			st_nxt.tmp_acc = tmp_sum;
			if (st_r.tmp_cnt == 6'h00) begin
				st_nxt.tmp_acc  = 22'(tmp_data);
				st_nxt.tmp_arm  = st_r.tmp_pend | tmp_req;
				st_nxt.tmp_pend = 2'b00;
			end
			if (st_r.tmp_cnt == 6'(`NSB_TMP_N - 1)) begin
				// streaming holds the gateway value after its one update
				if (st_r.tmp_arm[1] || !rt_mode) begin
					st_nxt.gw_tmp = mean({2'b00, tmp_sum}, `NSB_TMP_SH);
				end
				if (st_r.tmp_arm[0]) begin
					st_nxt.nd_tmp = mean({2'b00, tmp_sum}, `NSB_TMP_SH);
				end
				st_nxt.tmp_arm = 2'b00;
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r           <= '0;
			st_r.hdr.info1 <= `NSB_INFO1_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign miso       = st_r.miso;
	assign miso_oe    = st_r.miso_oe;
	assign sup_conv   = st_r.sup_conv;
	assign tmp_conv   = st_r.tmp_conv;
	assign action_go  = st_r.go;
	assign buf_index  = st_r.buf_idx;
	assign alm_select = st_r.alm_sel;
	assign rec_select = st_r.rec_ptr;

	// ============================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	localparam int sup_gap_val = `NSB_SUP_CYC - 1;
	logic [11:0] sup_gap_r;
	logic        sup_seen_r;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sup_gap_r  <= 12'h000;
			sup_seen_r <= 1'b0;
		end else if (st_r.sup_conv) begin
			sup_gap_r  <= 12'h000;
			sup_seen_r <= 1'b1;
		end else begin
			sup_gap_r <= sup_gap_r + 12'h001;
		end
	end

	// a fresh write of the bit in the issue cycle joins the running fetch and starts no new one
	sequence retr_issue;
		st_r.cmd[`NSB_CMD_RETR] && !st_r.rd_wait && !newset[`NSB_CMD_RETR];
	endsequence

	sequence retr_load;
		st_r.rd_wait ##1 (st_r.hdr.ts_lo == $past(mif.rd_data.ts_lo)
			&& !st_r.cmd[`NSB_CMD_RETR]);
	endsequence

	sup_rate_a : assert property (
		st_r.sup_conv && sup_seen_r |-> sup_gap_r == 12'(sup_gap_val))
		else $error("supply conversion spacing wrong");

	sup_mean_a : assert property (
		sup_vld && st_r.sup_cnt == 8'hff && !rt_mode
		|=> st_r.gw_sup == $past(sup_sum[23:8]))
		else $error("gateway supply is not the block mean");

	tmp_mean_a : assert property (
		tmp_vld && st_r.tmp_cnt == 6'h3f && st_r.tmp_arm[0]
		|=> st_r.nd_tmp == $past(tmp_sum[21:6]))
		else $error("node temperature is not the block mean");

	rt_hold_a : assert property (
		rt_mode && !st_r.sup_arm[1] |=> $stable(st_r.gw_sup))
		else $error("gateway supply moved during streaming");

	node_hold_a : assert property (
		!st_r.tmp_arm[0] |=> $stable(st_r.nd_tmp))
		else $error("node temperature moved without a record");

	cmd_set_a : assert property (
		frm_vld && frm[15] && st_r.page != 3'h0 && adr == `NSB_CMD_ADR
		|=> (st_r.cmd[7:0] & $past(frm[7:0])) == $past(frm[7:0]))
		else $error("command write did not set its bits");

	buf_zero_a : assert property (
		st_r.cmd[`NSB_CMD_BUFZ] && !newset[`NSB_CMD_BUFZ]
		|=> st_r.buf_idx == 9'h000 && !st_r.cmd[`NSB_CMD_BUFZ])
		else $error("buffer index not zeroed");

	retr_load_a : assert property (
		retr_issue |=> retr_load)
		else $error("record header not fetched in two cycles");

	st_result_a : assert property (
		cmd_done[`NSB_CMD_STEST] && st_r.cmd[`NSB_CMD_STEST]
		&& !st_r.cmd[`NSB_CMD_DCLR] && !st_r.go[`NSB_CMD_FACT]
		&& !st_r.go[`NSB_CMD_SWRST] && !st_r.rd_wait && !rec_evt
		|=> st_r.hdr.diag[`NSB_DIAG_ST_BIT] == $past(st_fail))
		else $error("self-test result not posted");

	diag_clr_a : assert property (
		st_r.cmd[`NSB_CMD_DCLR] |=> st_r.hdr.diag == 16'h0000)
		else $error("diagnostic flags not cleared");

	hdr_load_a : assert property (
		rec_evt && !st_r.rd_wait
		|=> st_r.hdr.ts_lo == $past(hdr_in.ts_lo)
		&& st_r.hdr.ts_hi == $past(hdr_in.ts_hi))
		else $error("record stamp not loaded");

endmodule : nsb_bank

// >>> rtl/nsb_defs.svh
`ifndef NSB_DEFS_SVH
`define NSB_DEFS_SVH

// ============================================================
// register byte addresses (a word sits at the even address)
`define NSB_PAGE_ADR      7'h00
`define NSB_ND_TMP_ADR    7'h0a
`define NSB_ND_SUP_ADR    7'h0c
`define NSB_GW_TMP_ADR    7'h0c
`define NSB_GW_SUP_ADR    7'h0e
`define NSB_BUF_ADR       7'h12
`define NSB_REC_ADR       7'h14
`define NSB_ALM_ADR       7'h1a
`define NSB_DIAG_ADR      7'h34
`define NSB_CMD_ADR       7'h36
`define NSB_AXS_ADR       7'h38
`define NSB_AYS_ADR       7'h3a
`define NSB_AXP_ADR       7'h3c
`define NSB_AYP_ADR       7'h3e
`define NSB_TSL_ADR       7'h40
`define NSB_TSH_ADR       7'h42
`define NSB_AXF_ADR       7'h44
`define NSB_AYF_ADR       7'h46
`define NSB_INF1_ADR      7'h4c
`define NSB_INF2_ADR      7'h4e

// ============================================================
// reset values and fields
`define NSB_INFO1_RST     16'h0008
`define NSB_DIAG_ST_BIT   5

// ============================================================
// command bit positions
`define NSB_CMD_STEST     2
`define NSB_CMD_FACT      3
`define NSB_CMD_DCLR      4
`define NSB_CMD_SWRST     7
`define NSB_CMD_BUFZ      10
`define NSB_CMD_RETR      13
// bits finished by this block rather than by cmd_done
`define NSB_CMD_INT_MASK  16'h2490

// ============================================================
// timing
`define NSB_CLK_HZ        125000000
`define NSB_CLK_NS        8
`define NSB_SUP_SPS       50000
`define NSB_SUP_CYC       (`NSB_CLK_HZ / `NSB_SUP_SPS)
`define NSB_SUP_N         256
`define NSB_SUP_SH        4'h8
`define NSB_TMP_WIN_NS    1700000
`define NSB_TMP_N         64
`define NSB_TMP_CYC       (`NSB_TMP_WIN_NS / (`NSB_CLK_NS * `NSB_TMP_N))
`define NSB_TMP_SH        4'h6

`endif

// >>> rtl/nsb_pkg.sv
package nsb_pkg;

	// ============================================================
	// one stored record header
	typedef struct packed {
		logic [15:0] diag;
		logic [15:0] ax_stat;
		logic [15:0] ay_stat;
		logic [15:0] ax_peak;
		logic [15:0] ay_peak;
		logic [15:0] ts_lo;
		logic [15:0] ts_hi;
		logic [15:0] ax_bin;
		logic [15:0] ay_bin;
		logic [15:0] info1;
		logic [15:0] info2;
	} nsb_hdr_type;

	// ============================================================
	// whole state of the bank; pend/arm bit 1 gateway, bit 0 node
	typedef struct packed {
		nsb_hdr_type hdr;
		logic [2:0]  page;
		logic [8:0]  buf_idx;
		logic [3:0]  rec_ptr;
		logic [7:0]  alm_sel;
		logic [15:0] cmd;
		logic [15:0] go;
		logic        rd_wait;
		logic        sclk_d;
		logic [15:0] sh;
		logic [3:0]  bits;
		logic [15:0] tx;
		logic        miso;
		logic        miso_oe;
		logic [23:0] sup_acc;
		logic [7:0]  sup_cnt;
		logic [11:0] sup_tmr;
		logic        sup_conv;
		logic [21:0] tmp_acc;
		logic [5:0]  tmp_cnt;
		logic [11:0] tmp_tmr;
		logic        tmp_conv;
		logic [15:0] gw_sup;
		logic [15:0] gw_tmp;
		logic [15:0] nd_sup;
		logic [15:0] nd_tmp;
		logic [1:0]  sup_pend;
		logic [1:0]  sup_arm;
		logic [1:0]  tmp_pend;
		logic [1:0]  tmp_arm;
		logic        rt_d;
	} nsb_state_type;

endpackage : nsb_pkg

// >>> rtl/nsb_mem_if.sv
interface nsb_mem_if;
	logic                wr_en;
	logic [3:0]          wr_addr;
	nsb_pkg::nsb_hdr_type wr_data;
	logic                rd_en;
	logic [3:0]          rd_addr;
	nsb_pkg::nsb_hdr_type rd_data;

	modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data);
endinterface : nsb_mem_if

// >>> rtl/nsb_hdr_mem.sv
module nsb_hdr_mem (
	input logic  clk_sys,
	nsb_mem_if.mem port
);
	// sixteen slots, the upper two unused by a fourteen record store
	nsb_pkg::nsb_hdr_type store [16];

	always_ff @(posedge clk_sys) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_en) begin
			port.rd_data <= store[port.rd_addr];
		end
	end
endmodule : nsb_hdr_mem

// >>> testbench/nsb_host_model.sv
// ============================================================
// host processor side of the serial register port, mode 3
module nsb_host_model (
	input  wire logic clk_sys,
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;

	// sclk stands still high between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_clk

	// three-cycle phases leave margin over the two-cycle minimum
	task automatic xfer(input logic [15:0] dout, output logic [15:0] din);
		din = 16'h0000;
		cs_n = 1'b0;
		wait_clk(2);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = dout[i];
			wait_clk(3);
			din[i] = miso;
			sclk = 1'b1;
			wait_clk(3);
		end
		cs_n = 1'b1;
		// released line shows no stale bit
		mosi = ~mosi;
		wait_clk(2);
	endtask : xfer
endmodule : nsb_host_model

// >>> testbench/test_node_status_header_command_bank.sv
module test_node_status_header_command_bank;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk_sys = 1'b0;
	logic              reset = 1'b1;
	logic              sclk, cs_n, mosi, miso, miso_oe;
	logic              sup_conv, tmp_conv;
	logic              sup_vld = 1'b0;
	logic              tmp_vld = 1'b0;
	logic [15:0]       sup_data = 16'h0000;
	logic [15:0]       tmp_data = 16'h0000;
	logic              rt_mode = 1'b0;
	logic              rec_done = 1'b0;
	logic              rec_evt = 1'b0;
	logic [3:0]        rec_slot = 4'h0;
	logic [175:0]      hdr_in = '0;
	logic [15:0]       cmd_done = 16'h0000;
	logic              st_fail = 1'b0;
	logic [15:0]       action_go, go_seen;
	logic [8:0]        buf_index;
	logic [7:0]        alm_select;
	logic [3:0]        rec_select;
	int                err_total = 0;
	int                n_tests = 0;
	logic [6:0]        hdr_adr [11] = '{7'h34, 7'h38, 7'h3a, 7'h3c,
		7'h3e, 7'h40, 7'h42, 7'h44, 7'h46, 7'h4c, 7'h4e};

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) go_seen = go_seen | action_go;

	nsb_host_model host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso));

	nsb_bank i_dut (.clk_sys(clk_sys), .reset(reset), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.sup_conv(sup_conv), .sup_vld(sup_vld), .sup_data(sup_data),
		.tmp_conv(tmp_conv), .tmp_vld(tmp_vld), .tmp_data(tmp_data),
		.rt_mode(rt_mode), .rec_done(rec_done), .rec_evt(rec_evt),
		.rec_slot(rec_slot), .hdr_in(hdr_in), .cmd_done(cmd_done),
		.st_fail(st_fail), .action_go(action_go), .buf_index(buf_index),
		.alm_select(alm_select), .rec_select(rec_select));

	// ============================================================
	// common tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic clk_n(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : clk_n

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] x;
		host.xfer({1'b1, a, d}, x);
	endtask : wr

	// the answer arrives in the following frame
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		host.xfer({1'b0, a, 8'h00}, d);
		host.xfer(16'h0000, d);
	endtask : rd

	function automatic logic [175:0] mk_hdr(input int k);
		logic [175:0] w;
		for (int i = 0; i < 11; i++) w[175-16*i -: 16] = 16'(k * 16'h1100 + i);
		w[31:16] = {k[1:0], k[1:0], k[1:0], 2'b00, (k == 3) ? 8'hff : 8'(k)};
		return w;
	endfunction : mk_hdr

	task automatic chk_hdr(input logic [175:0] h);
		logic [15:0] d;
		for (int i = 0; i < 11; i++) begin
			rd(hdr_adr[i], d);
			chk("header word", d, h[175-16*i -: 16]);
		end
	endtask : chk_hdr

	// supply stays healthy for every command issued here
	task automatic cmd(input int b);
		go_seen = 16'h0000;
		wr((b > 7) ? 7'h37 : 7'h36, 8'(1 << (b % 8)));
		for (int i = 0; i < 20 && go_seen === 16'h0000; i++) clk_n(1);
		if (go_seen === 16'h0000) begin
			err_total++;
			final_report();
		end
		chk("action_go", go_seen, 16'(1 << b));
		if (!(b inside {13, 10, 7, 4})) begin
			clk_n(2);
			cmd_done[b] = 1'b1;
			clk_n(1);
			cmd_done = 16'h0000;
			clk_n(2);
		end
	endtask : cmd

	// ============================================================
	// scenarios
	task automatic t_reset();
		logic [15:0] d;
		chk("go at reset", action_go, 16'h0000);
		chk("oe idle", 16'(miso_oe), 16'h0000);
		chk("sel at reset", {buf_index, alm_select[6:0]}, 16'h0000);
		wr(7'h12, 8'h33);
		chk("page0 refused", 16'(buf_index), 16'h0000);
		wr(7'h00, 8'h01);
		chk_hdr({144'h0, 16'h0008, 16'h0000});
		rd(7'h7e, d);
		chk("unmapped", d, 16'h0000);
		rd(7'h36, d);
		chk("cmd reads 0", d, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_header();
		logic [15:0]  d;
		logic [175:0] h;
		for (int k = 0; k < 4; k++) begin
			h = mk_hdr(k);
			hdr_in = h;
			rec_slot = 4'(k);
			rec_evt = 1'b1;
			clk_n(1);
			rec_evt = 1'b0;
			clk_n(1);
			rd(7'h4c, d);
			chk("info1", d, h[31:16]);
		end
		chk_hdr(mk_hdr(3));
		wr(7'h14, 8'h01);
		chk("rec_select", 16'(rec_select), 16'h0001);
		cmd(13);
		chk_hdr(mk_hdr(1));
		$display("test header done");
	endtask : t_header

	task automatic t_cmds();
		logic [15:0] d;
		st_fail = 1'b1;
		for (int b = 0; b < 16; b++) begin
			wr(7'h00, 8'h01);
			if (b == 10) wr(7'h12, 8'h9f);
			if (b == 3) wr(7'h1a, 8'h05);
			// the selector is only ever written just before the restore
			chk("alm pre", 16'(alm_select), (b == 3) ? 16'h0005 : 16'h0000);
			cmd(b);
			if (b == 10) chk("buf_index", 16'(buf_index), 16'h0000);
			if (b == 3) chk("alm factory", 16'(alm_select), 16'h0000);
			if (b == 2) begin
				rd(7'h34, d);
				chk("selftest fail", 16'(d[5]), 16'h0001);
			end
		end
		st_fail = 1'b0;
		wr(7'h00, 8'h01);
		cmd(2);
		rd(7'h34, d);
		chk("selftest pass", 16'(d[5]), 16'h0000);
		cmd(4);
		rd(7'h34, d);
		chk("diag clear", d, 16'h0000);
		$display("test commands done");
	endtask : t_cmds

	// alternating codes two apart average to the code between
	task automatic feed(input logic [15:0] sv, input logic [15:0] tv);
		for (int i = 0; i < 256; i++) begin
			sup_vld = 1'b1;
			sup_data = sv + {i[0], 1'b0};
			tmp_vld = (i < 64);
			tmp_data = tv + {i[0], 1'b0};
			clk_n(1);
			sup_vld = 1'b0;
			tmp_vld = 1'b0;
			clk_n(1);
		end
		clk_n(4);
	endtask : feed

	task automatic rd_meas(input logic [15:0] s, input logic [15:0] t,
		input bit node);
		logic [15:0] d;
		wr(7'h00, 8'(node));
		rd(node ? 7'h0c : 7'h0e, d);
		chk("supply", d, s);
		rd(node ? 7'h0a : 7'h0c, d);
		chk("temperature", d, t);
	endtask : rd_meas

	task automatic t_meas();
		int n;
		feed(16'd7500, 16'd4584);
		rd_meas(16'd7501, 16'd4585, 1'b0);
		rec_done = 1'b1;
		clk_n(1);
		rec_done = 1'b0;
		feed(16'd7158, 16'd5074);
		rd_meas(16'd7159, 16'd5075, 1'b1);
		rt_mode = 1'b1;
		feed(16'd8181, 16'd3049);
		feed(16'd7498, 16'd4582);
		rd_meas(16'd8182, 16'd3050, 1'b0);
		rd_meas(16'd8182, 16'd3050, 1'b1);
		for (n = 0; n < 3000 && !sup_conv; n++) clk_n(1);
		n = 0;
		do begin
			clk_n(1);
			n++;
		end while (n < 3000 && !sup_conv);
		chk("supply spacing", 16'(n), 16'd2500);
		for (n = 0; n < 4000 && !tmp_conv; n++) clk_n(1);
		n = 0;
		do begin
			clk_n(1);
			n++;
		end while (n < 4000 && !tmp_conv);
		chk("temp spacing", 16'(n), 16'd3320);
		$display("test measurement done");
	endtask : t_meas

	// ============================================================
	// main sequence and hang guard
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		t_reset();
		t_header();
		t_cmds();
		t_meas();
		final_report();
	end

	initial begin
		#700us;
		err_total++;
		final_report();
	end
endmodule : test_node_status_header_command_bank
